// *** src/group_signal_map.sv ***
module group_signal_map (
	input wire logic [1:0] group,
	input wire logic [1:0] level,
	input wire logic security_off,
	input wire logic [2:0] group_enable,
	input wire logic pending,
	output logic irq,
	output logic fiq
);
	logic [1:0] grp_eff;
	logic en;
	logic to_irq;
	always_comb begin
		grp_eff = group;
		if (security_off && group == mcr_pkg::GRP_G1S) begin
			grp_eff = mcr_pkg::GRP_G1NS; // R16
		end
		en = 1'b0;
		case (grp_eff)
			mcr_pkg::GRP_G0: en = group_enable[mcr_pkg::CT_EN_G0]; // R12
			mcr_pkg::GRP_G1S: en = group_enable[mcr_pkg::CT_EN_G1S];
			mcr_pkg::GRP_G1NS: en = group_enable[mcr_pkg::CT_EN_G1NS];
			default: en = 1'b0;
		endcase
		to_irq = 1'b0;
		if (security_off) begin
			to_irq = (grp_eff != mcr_pkg::GRP_G0);
		end else begin
			case (level)
				mcr_pkg::LVL_SEC_EL01: to_irq = (grp_eff == mcr_pkg::GRP_G1S); // R13
				mcr_pkg::LVL_NS: to_irq = (grp_eff == mcr_pkg::GRP_G1NS); // R13
				mcr_pkg::LVL_EL3: to_irq = 1'b0; // R13
				default: to_irq = 1'b0;
			endcase
		end
		// Group 0 never signals IRQ while secure
		irq = pending && en && to_irq; // R18
		fiq = pending && en && !to_irq;
	end
endmodule : group_signal_map

// *** src/mcr_pkg.sv ***
// Functional notes
// R1: Up to 16 chips supported, each chip with its own controller.
// R2: Every chip keeps a full route table, entry index equals chip identifier.
// R3: Default owner register names the consistency chip and shows update pending.
// R4: After reset each chip is standalone and status reports disconnected.
// R5: When connected, shared interrupts are grouped in blocks of 32, one owner each.
// R6: Shared interrupts in blocks owned by no chip are never delivered.
// R7: Wires accepted only for owned blocks; messages accepted for any owned block.
// R8: One table operation at a time; software checks pending is zero first.
// R9: Local addressing off: one common address per destination chip.
// R10: Local addressing on: each chip uses its own per-destination address.
// R11: Read-only configuration bit shows the local addressing setting.
// R12: Three groups, each with its own forwarding enable.
// R13: Group to IRQ or FIQ mapping depends on core exception level and security.
// R14: Security disable tie-off sampled on leaving reset; high disables security.
// R15: Read-only control bit reports the sampled security disable state.
// R16: With security disabled only one security state and fewer groups.
// R17: Systems without security must tie the disable input high.
// R18: With security enabled Group 0 is always Secure.
// R19: Mixed systems keep security on; cores enable only groups they support.
package mcr_pkg;
	localparam int unsigned MAX_CHIPS = 16;
	localparam int unsigned CHIP_W = 4;
	localparam int unsigned BLK_W = 6;
	localparam int unsigned BLK_SIZE = 32;
	localparam int unsigned BLK_SHIFT = 5;
	localparam int unsigned NUM_BLOCKS = 8;
	localparam int unsigned ADDR_W = 8;
	// Byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFGID = 8'h04;
	localparam logic [7:0] OFS_DEFCHIP = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_ROUTE = 8'h40;
	localparam logic [7:0] ROUTE_END = 8'h80;
	// Route entry fields
	localparam int unsigned RE_VALID = 0;
	localparam int unsigned RE_BASE_LSB = 1;
	localparam int unsigned RE_CNT_LSB = 7;
	localparam int unsigned RE_ADDR_LSB = 16;
	// Control fields
	localparam int unsigned CT_EN_G0 = 0;
	localparam int unsigned CT_EN_G1S = 1;
	localparam int unsigned CT_EN_G1NS = 2;
	localparam int unsigned CT_DS = 6;
	localparam int unsigned CT_LEVEL_LSB = 8;
	// Other fields
	localparam int unsigned DC_PUP = 31;
	localparam int unsigned DC_VALID = 4;
	localparam int unsigned ST_RTS_LSB = 0;
	localparam int unsigned CFG_LCA = 0;
	localparam logic [1:0] RTS_DISCONNECTED = 2'h0;
	localparam logic [1:0] RTS_UPDATING = 2'h1;
	localparam logic [1:0] RTS_CONNECTED = 2'h2;
	localparam int unsigned UPDATE_CYCLES = 4;
	typedef enum logic [1:0] {
		GRP_G0 = 2'h0,
		GRP_G1S = 2'h1,
		GRP_G1NS = 2'h2
	} grp_e;
	typedef enum logic [1:0] {
		LVL_SEC_EL01 = 2'h0,
		LVL_NS = 2'h1,
		LVL_EL3 = 2'h2
	} level_e;
endpackage : mcr_pkg

// *** src/multichip_routing_security.sv ***
// The Wishbone register port and the register offsets were left to the implementer.
module multichip_routing_security #(
	parameter int unsigned NUM_CHIPS = mcr_pkg::MAX_CHIPS,
	parameter bit LOCAL_ADDR = 1'b0,
	parameter logic [7:0] NUM_SPI_BLOCKS = 8'h08
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [3:0] chip_identifier_input,
	input wire logic security_disable_tieoff,
	input wire logic spi_wire_valid,
	input wire logic [10:0] spi_wire_id,
	input wire logic spi_msg_valid,
	input wire logic [10:0] spi_msg_id,
	input wire logic [1:0] spi_group,
	output logic spi_accept,
	output logic spi_local,
	output logic [3:0] spi_owner,
	output logic [7:0] spi_dest_addr,
	output logic irq,
	output logic fiq
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_UPDATE = 3'b010,
		ST_DONE = 3'b100
	} upd_e;

	logic [31:0] route_q [mcr_pkg::MAX_CHIPS];
	logic [31:0] ctrl_q;
	logic [4:0] defchip_q;
	logic [1:0] rts_q;
	logic ds_q;
	logic ds_s1_q;
	logic ds_s2_q;
	logic [3:0] chip_identifier_input_s1_q;
	logic [3:0] chip_identifier_input_s2_q;
	logic reset_seen_q;
	upd_e upd_q;
	logic [2:0] upd_cnt_q;
	logic ack_q;
	logic err_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic wr_ok;
	logic req;
	logic mapped;
	logic is_route;
	logic [3:0] route_idx;
	logic pending;

	assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	assign is_route = wb_adr_i >= mcr_pkg::OFS_ROUTE && wb_adr_i < mcr_pkg::ROUTE_END;
	assign route_idx = wb_adr_i[5:2];
	assign pending = (upd_q != ST_IDLE);
	assign mapped = is_route || wb_adr_i == mcr_pkg::OFS_CTRL || wb_adr_i == mcr_pkg::OFS_CFGID
		|| wb_adr_i == mcr_pkg::OFS_DEFCHIP || wb_adr_i == mcr_pkg::OFS_STATUS;
	// Full-word writes only; table writes refused while an update runs
	assign wr_ok = req && wb_we_i && mapped && wb_sel_i == 4'hF;

	// Pin synchronisers
	always_ff @(posedge clk) begin
		ds_s1_q <= security_disable_tieoff;
		ds_s2_q <= ds_s1_q;
		chip_identifier_input_s1_q <= chip_identifier_input;
		chip_identifier_input_s2_q <= chip_identifier_input_s1_q;
	end

	// Tie-off captured on the first cycle after reset release
	always_ff @(posedge clk) begin
		if (rst) begin
			reset_seen_q <= 1'b1;
			ds_q <= 1'b0;
		end else if (reset_seen_q) begin
			reset_seen_q <= 1'b0;
			ds_q <= ds_s2_q; // R14
		end
	end

	// Control register: group enables and core level
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= 32'h0000_0000;
		end else if (wr_ok && wb_adr_i == mcr_pkg::OFS_CTRL) begin
			ctrl_q <= {22'h0, wb_dat_i[mcr_pkg::CT_LEVEL_LSB+1:mcr_pkg::CT_LEVEL_LSB], 5'h0,
				wb_dat_i[mcr_pkg::CT_EN_G1NS:mcr_pkg::CT_EN_G0]}; // R12
		end
	end

	// Route table, one entry per chip
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < int'(mcr_pkg::MAX_CHIPS); i++) begin
				route_q[i] <= 32'h0000_0000;
			end
		end else if (wr_ok && is_route && !pending && 32'(route_idx) < NUM_CHIPS) begin
			route_q[route_idx] <= wb_dat_i; // R2 R8
		end
	end

	// Default owner register
	always_ff @(posedge clk) begin
		if (rst) begin
			defchip_q <= 5'h00;
		end else if (wr_ok && wb_adr_i == mcr_pkg::OFS_DEFCHIP && !pending) begin
			defchip_q <= wb_dat_i[mcr_pkg::DC_VALID:0]; // R3 R8
		end
	end

	// Update interlock sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			upd_q <= ST_IDLE;
			upd_cnt_q <= 3'h0;
		end else begin
			case (upd_q)
				ST_IDLE: begin
					if (wr_ok && (is_route || wb_adr_i == mcr_pkg::OFS_DEFCHIP)) begin
						upd_q <= ST_UPDATE; // R8
						upd_cnt_q <= 3'(mcr_pkg::UPDATE_CYCLES - 1);
					end
				end
				ST_UPDATE: begin
					if (upd_cnt_q == 3'h0) begin
						upd_q <= ST_DONE;
					end else begin
						upd_cnt_q <= upd_cnt_q - 3'h1;
					end
				end
				ST_DONE: upd_q <= ST_IDLE;
				default: upd_q <= ST_IDLE;
			endcase
		end
	end

	// Link status
	always_ff @(posedge clk) begin
		if (rst) begin
			rts_q <= mcr_pkg::RTS_DISCONNECTED; // R4
		end else if (upd_q == ST_UPDATE) begin
			rts_q <= mcr_pkg::RTS_UPDATING;
		end else if (upd_q == ST_DONE) begin
			rts_q <= defchip_q[mcr_pkg::DC_VALID] ? mcr_pkg::RTS_CONNECTED
				: mcr_pkg::RTS_DISCONNECTED;
		end
	end

	// Read mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (is_route) begin
			rdata_d = 32'(route_idx) < NUM_CHIPS ? route_q[route_idx] : 32'h0000_0000;
		end else begin
			case (wb_adr_i)
				mcr_pkg::OFS_CTRL: begin
					rdata_d = ctrl_q;
					rdata_d[mcr_pkg::CT_DS] = ds_q; // R15
				end
				mcr_pkg::OFS_CFGID: rdata_d[mcr_pkg::CFG_LCA] = LOCAL_ADDR; // R11
				mcr_pkg::OFS_DEFCHIP: begin
					rdata_d[mcr_pkg::DC_VALID:0] = defchip_q;
					rdata_d[mcr_pkg::DC_PUP] = pending; // R3
				end
				mcr_pkg::OFS_STATUS: begin
					rdata_d[mcr_pkg::ST_RTS_LSB+1:mcr_pkg::ST_RTS_LSB] = rts_q; // R4
					rdata_d[11:8] = chip_identifier_input_s2_q;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Bus answer one cycle after request
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && mapped;
			err_q <= req && !mapped;
			rdata_q <= (req && mapped && !wb_we_i) ? rdata_d : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdata_q;

	// Block ownership lookup
	logic [10:0] sel_id;
	logic [5:0] sel_blk;
	logic [mcr_pkg::MAX_CHIPS-1:0] hit;
	logic owned;
	logic [3:0] owner;
	logic connected;

	assign sel_id = spi_wire_valid ? spi_wire_id : spi_msg_id;
	assign sel_blk = sel_id[10:mcr_pkg::BLK_SHIFT]; // R5
	assign connected = (rts_q == mcr_pkg::RTS_CONNECTED);

	genvar g;
	generate
		for (g = 0; g < int'(mcr_pkg::MAX_CHIPS); g++) begin : g_own
			logic [5:0] base;
			logic [6:0] lim;
			assign base = route_q[g][mcr_pkg::RE_BASE_LSB+5:mcr_pkg::RE_BASE_LSB];
			assign lim = 7'(base) + 7'(route_q[g][mcr_pkg::RE_CNT_LSB+5:mcr_pkg::RE_CNT_LSB]);
			assign hit[g] = (g < NUM_CHIPS) && route_q[g][mcr_pkg::RE_VALID]
				&& sel_blk >= base && 7'(sel_blk) < lim; // R1 R5
		end
	endgenerate

	always_comb begin
		owned = 1'b0;
		owner = 4'h0;
		for (int i = int'(mcr_pkg::MAX_CHIPS) - 1; i >= 0; i--) begin
			if (hit[i]) begin
				owned = 1'b1;
				owner = 4'(i);
			end
		end
	end

	logic accept_d;
	logic local_d;
	logic [7:0] addr_d;
	always_comb begin
		local_d = owned && owner == chip_identifier_input_s2_q;
		accept_d = 1'b0;
		if (!connected) begin
			// Standalone: everything in range is local
			accept_d = (spi_wire_valid || spi_msg_valid) && 8'(sel_blk) < NUM_SPI_BLOCKS; // R4
			local_d = accept_d;
		end else if (spi_wire_valid) begin
			accept_d = owned && local_d; // R6 R7
		end else if (spi_msg_valid) begin
			accept_d = owned; // R6 R7
		end
		// Common or per-source destination address
		if (LOCAL_ADDR) begin
			addr_d = route_q[owner][mcr_pkg::RE_ADDR_LSB+7:mcr_pkg::RE_ADDR_LSB]
				^ {4'h0, chip_identifier_input_s2_q}; // R10
		end else begin
			addr_d = route_q[owner][mcr_pkg::RE_ADDR_LSB+7:mcr_pkg::RE_ADDR_LSB]; // R9
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			spi_accept <= 1'b0;
			spi_local <= 1'b0;
			spi_owner <= 4'h0;
			spi_dest_addr <= 8'h00;
		end else begin
			spi_accept <= accept_d;
			spi_local <= accept_d && local_d;
			spi_owner <= connected ? owner : chip_identifier_input_s2_q;
			spi_dest_addr <= accept_d ? addr_d : 8'h00;
		end
	end

	logic irq_d;
	logic fiq_d;
	group_signal_map u_map (
		.group(spi_group),
		.level(ctrl_q[mcr_pkg::CT_LEVEL_LSB+1:mcr_pkg::CT_LEVEL_LSB]),
		.security_off(ds_q), // R16
		.group_enable(ctrl_q[mcr_pkg::CT_EN_G1NS:mcr_pkg::CT_EN_G0]),
		.pending(accept_d && local_d),
		.irq(irq_d),
		.fiq(fiq_d)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
			fiq <= 1'b0;
		end else begin
			irq <= irq_d; // R13
			fiq <= fiq_d;
		end
	end
endmodule : multichip_routing_security

// *** tb/multichip_routing_security_props.sv ***
module multichip_routing_security_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic spi_wire_valid,
	input wire logic spi_msg_valid,
	input wire logic spi_accept,
	input wire logic spi_local,
	input wire logic [7:0] spi_dest_addr,
	input wire logic irq,
	input wire logic fiq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	property p_answer;
		take |=> (wb_ack_o || wb_err_o);
	endproperty
	a_answer: assert property (p_answer) else $error("Request not answered");
	property p_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("Ack longer than one cycle");
	property p_unmapped;
		take && wb_adr_i >= 8'h80 |=> wb_err_o && !wb_ack_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Out of range entry not refused");
	property p_idle;
		!spi_wire_valid && !spi_msg_valid |=> !spi_accept;
	endproperty
	a_idle: assert property (p_idle) else $error("Accept without request");
	property p_local;
		spi_local |-> spi_accept;
	endproperty
	a_local: assert property (p_local) else $error("Local without accept");
	property p_excl;
		irq |-> !fiq;
	endproperty
	a_excl: assert property (p_excl) else $error("Both irq and fiq");
	property p_sig;
		(irq || fiq) |-> spi_local;
	endproperty
	a_sig: assert property (p_sig) else $error("Signal for non local interrupt");
	property p_dest;
		!spi_accept |-> spi_dest_addr == 8'h00;
	endproperty
	a_dest: assert property (p_dest) else $error("Address without accept");
	property p_quiet;
		$fell(rst) |-> !spi_accept && !irq && !fiq && !wb_ack_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("Output active after reset");
	c_err: cover property (wb_err_o);
	c_irq: cover property (irq);
	c_fiq: cover property (fiq);
	c_remote: cover property (spi_accept && !spi_local);
endmodule : multichip_routing_security_props

bind multichip_routing_security multichip_routing_security_props multichip_routing_security_props_inst (
	.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .spi_wire_valid(spi_wire_valid),
	.spi_msg_valid(spi_msg_valid), .spi_accept(spi_accept), .spi_local(spi_local),
	.spi_dest_addr(spi_dest_addr), .irq(irq), .fiq(fiq));

// *** tb/spi_source_model.sv ***
module spi_source_model (
	input wire logic clk,
	output logic wire_valid,
	output logic [10:0] wire_id,
	output logic msg_valid,
	output logic [10:0] msg_id,
	output logic [1:0] group
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		wire_valid = 1'b0;
		msg_valid = 1'b0;
		wire_id = 11'h000;
		msg_id = 11'h000;
		group = 2'h0;
	end
	// One cycle request, id lines scrambled after release
	task automatic present(input logic by_wire, input logic [10:0] id, input logic [1:0] grp);
		@(posedge clk);
		wire_valid <= by_wire;
		msg_valid <= !by_wire;
		wire_id <= id;
		msg_id <= id;
		group <= grp;
		@(posedge clk);
		wire_valid <= 1'b0;
		msg_valid <= 1'b0;
		wire_id <= ~id;
		msg_id <= ~id;
		group <= ~grp;
	endtask : present
endmodule : spi_source_model

// *** tb/test_multichip_routing_security.sv ***
module test_multichip_routing_security;
	timeunit 1ns;
	timeprecision 100ps;
	localparam bit LA = 1'b0;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic tieoff = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, wb_err_o, wv, mv, spi_accept, spi_local, irq, fiq;
	logic [10:0] wid, mid;
	logic [1:0] grp;
	logic [3:0] spi_owner;
	logic [7:0] spi_dest_addr;
	int n_fail = 0;
	int total_checks = 0;
	always #25 clk = ~clk;
	multichip_routing_security #(.NUM_CHIPS(16), .LOCAL_ADDR(LA), .NUM_SPI_BLOCKS(8'h08))
	multichip_routing_security_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .chip_identifier_input(4'h2),
		.security_disable_tieoff(tieoff), .spi_wire_valid(wv), .spi_wire_id(wid),
		.spi_msg_valid(mv), .spi_msg_id(mid), .spi_group(grp), .spi_accept(spi_accept),
		.spi_local(spi_local), .spi_owner(spi_owner), .spi_dest_addr(spi_dest_addr),
		.irq(irq), .fiq(fiq));
	spi_source_model spi_source_model_inst (.clk(clk), .wire_valid(wv), .wire_id(wid),
		.msg_valid(mv), .msg_id(mid), .group(grp));
	task automatic conclude;
		if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (!(wb_ack_o || wb_err_o) && n < 20);
		q = wb_err_o ? 32'hEEEEEEEE : wb_dat_o;
		if (n >= 20) n_fail++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask : rdc
	task automatic settle;
		logic [31:0] q;
		q = 32'hFFFFFFFF;
		for (int i = 0; i < 20 && q[31] !== 1'b0; i++) bus(1'b0, 8'h08, 32'h0, q);
	endtask : settle
	task automatic fire(input logic w, input logic [10:0] id, input logic [1:0] g,
		input logic [15:0] m, input logic [15:0] e);
		spi_source_model_inst.present(w, id, g);
		#1;
		chk(32'({spi_dest_addr, irq, fiq, spi_accept, spi_local, spi_owner} & m), 32'(e));
	endtask : fire
	task automatic do_reset;
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task automatic t_reset_values;
		rdc(mcr_pkg::OFS_CTRL, 32'h40, 32'h0);
		rdc(mcr_pkg::OFS_CFGID, 32'h1, {31'h0, LA});
		rdc(mcr_pkg::OFS_STATUS, 32'hF03, 32'h200);
		rdc(8'h10, 32'hFFFFFFFF, 32'hEEEEEEEE);
		rdc(8'h80, 32'hFFFFFFFF, 32'hEEEEEEEE);
	endtask : t_reset_values
	task automatic t_groups;
		logic ie;
		for (int lv = 0; lv < 3; lv++) begin
			wr(mcr_pkg::OFS_CTRL, {22'h0, lv[1:0], 8'h07});
			for (int g = 0; g < 3; g++) begin
				ie = (lv == 0 && g == 1) || (lv == 1 && g == 2);
				fire(1'b0, 11'(20 + g), g[1:0], 16'h00FF, {8'h0, ie, !ie, 6'h32});
			end
		end
		wr(mcr_pkg::OFS_CTRL, 32'h0);
		fire(1'b1, 11'd21, 2'h1, 16'h00FF, 16'h0032);
	endtask : t_groups
	task automatic t_route;
		wr(8'h48, 32'h00220081);
		rdc(8'h08, 32'h80000000, 32'h80000000);
		settle;
		wr(8'h54, 32'h005A0083);
		wr(8'h5C, 32'h00770001);
		settle;
		rdc(8'h5C, 32'hFFFFFFFF, 32'h0);
		wr(8'h08, 32'h12);
		settle;
		rdc(mcr_pkg::OFS_STATUS, 32'hF03, 32'h202);
		fire(1'b1, 11'd40, 2'h2, 16'hFFF0, 16'h0);
		fire(1'b0, 11'd40, 2'h2, 16'hFFFF, 16'h5A25);
		fire(1'b0, 11'd100, 2'h2, 16'hFFF0, 16'h0);
		fire(1'b1, 11'd100, 2'h2, 16'hFFF0, 16'h0);
		fire(1'b1, 11'd10, 2'h2, 16'hFFFF, 16'h2232);
	endtask : t_route
	task automatic t_secoff;
		@(posedge clk);
		tieoff <= 1'b1;
		do_reset;
		rdc(mcr_pkg::OFS_CTRL, 32'h40, 32'h40);
		wr(mcr_pkg::OFS_CTRL, 32'h207);
		fire(1'b0, 11'd20, 2'h1, 16'h00FF, 16'h00B2);
		fire(1'b0, 11'd20, 2'h0, 16'h00FF, 16'h0072);
	endtask : t_secoff
	initial begin
		do_reset;
		t_reset_values;
		t_groups;
		t_route;
		t_secoff;
		conclude;
	end
	initial begin
		#100us;
		n_fail++;
		conclude;
	end
endmodule : test_multichip_routing_security
